// [msm_pkg.sv]
// Package for the multiply-subtract datapath with parallel move.
// Assumes one 10 MHz CPU clock and an AXI4-Lite register master.
package msm_pkg;
  localparam int MSM_ACC_W   = 40;
  localparam int MSM_WORD_W  = 16;
  localparam int MSM_OPND_W  = 17;
  localparam int MSM_PROD_W  = 34;
  localparam int MSM_PTR_W   = 16;
  // Byte offsets of the register map
  localparam logic [7:0] MSM_REG_CTRL   = 8'h00;
  localparam logic [7:0] MSM_REG_STATUS = 8'h04;
  localparam logic [7:0] MSM_REG_ACC1_L = 8'h08;
  localparam logic [7:0] MSM_REG_ACC1_H = 8'h0C;
  localparam logic [7:0] MSM_REG_ACC2_L = 8'h10;
  localparam logic [7:0] MSM_REG_ACC2_H = 8'h14;
  localparam logic [7:0] MSM_REG_TREGS  = 8'h18;
  localparam logic [7:0] MSM_REG_PTRS   = 8'h1C;
  // Control register bit positions
  localparam int MSM_B_FRACTIONAL_MODE  = 0;
  localparam int MSM_B_MULTIPLY_SATURATE_MODE  = 1;
  localparam int MSM_B_M40   = 2;
  localparam int MSM_B_RDM   = 3;
  localparam int MSM_B_ACCUMULATOR_SATURATE_MODE  = 4;
  localparam int MSM_B_SIGN_EXTENSION_MODE  = 5;
  localparam int MSM_B_SST   = 6;
  localparam int MSM_B_LEG   = 7;
  localparam int MSM_CTRL_W  = 8;
  localparam logic [MSM_CTRL_W-1:0] MSM_CTRL_RST = 8'h20;
  // Status bits, write one to clear
  localparam int MSM_B_OV1   = 0;
  localparam int MSM_B_OV2   = 1;
  // Shift limits and pointer step
  localparam logic signed [15:0] MSM_SHIFT_MIN = 16'shFFE0;
  localparam logic signed [15:0] MSM_SHIFT_MAX = 16'sh001F;
  localparam logic signed [6:0]  MSM_LEG_WRAP  = 7'sh10;
  localparam logic signed [6:0]  MSM_LEG_LOW   = 7'sh6F;
  localparam logic [MSM_PTR_W-1:0] MSM_PAIR_STEP = 16'h0002;
  localparam logic [MSM_PTR_W-1:0] MSM_ONE_STEP  = 16'h0001;
  localparam logic [1:0] MSM_RESP_OK  = 2'h0;
  localparam logic [1:0] MSM_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {MSM_OP_NONE, MSM_OP_LOAD, MSM_OP_STORE, MSM_OP_DUAL} msm_op_t;
endpackage

// [msm_mac_subtract_move.sv]
// Multiply-subtract datapath with parallel load or saturating store.
// Assumes the decoder presents one instruction per issue pulse with
// memory operands valid in that cycle; registers over AXI4-Lite.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module msm_mac_subtract_move
  import msm_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Decoder side
  input  wire logic                  issue,
  input  wire msm_op_t               op_kind,
  input  wire logic                  dest_is_second,
  input  wire logic                  opt_round,
  input  wire logic                  opt_capture,
  input  wire logic                  opt_uns_x,
  input  wire logic                  opt_uns_t,
  input  wire logic                  opt_local_m40,
  input  wire logic                  ptr_post_mod,
  input  wire logic [MSM_WORD_W-1:0] mult_temp,
  input  wire logic [MSM_WORD_W-1:0] xmem_data,
  input  wire logic [MSM_WORD_W-1:0] ymem_data,
  output logic [MSM_WORD_W-1:0]      ymem_wdata,
  output logic                       ymem_we,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  logic [MSM_CTRL_W-1:0]    ctrl;
  logic                     first_acc_overflow_flag;
  logic                     second_acc_overflow_flag;
  logic [MSM_ACC_W-1:0]     first_accumulator;
  logic [MSM_ACC_W-1:0]     second_accumulator;
  logic [MSM_WORD_W-1:0]    shift_count_register;
  logic [MSM_WORD_W-1:0]    operand_capture_register;
  logic [MSM_PTR_W-1:0]     data_pointer;
  logic [MSM_PTR_W-1:0]     coefficient_pointer;
  logic                     fractional_mode;
  logic                     multiply_saturate_mode;
  logic                     wide_40bit_mode;
  logic                     rounding_mode;
  logic                     accumulator_saturate_mode;
  logic                     sign_extension_mode;
  logic                     store_saturate_mode;
  logic                     legacy_compat_mode;

  assign fractional_mode           = ctrl[MSM_B_FRACTIONAL_MODE];
  assign multiply_saturate_mode    = ctrl[MSM_B_MULTIPLY_SATURATE_MODE];
  assign wide_40bit_mode           = ctrl[MSM_B_M40];
  assign rounding_mode             = ctrl[MSM_B_RDM];
  assign accumulator_saturate_mode = ctrl[MSM_B_ACCUMULATOR_SATURATE_MODE];
  assign sign_extension_mode       = ctrl[MSM_B_SIGN_EXTENSION_MODE];
  assign store_saturate_mode       = ctrl[MSM_B_SST];
  assign legacy_compat_mode        = ctrl[MSM_B_LEG];

  // Multiply-subtract arithmetic, all combinational in the issue cycle
  logic signed [MSM_OPND_W-1:0] op_a;
  logic signed [MSM_OPND_W-1:0] op_b;
  logic signed [MSM_PROD_W-1:0] prod;
  logic signed [MSM_PROD_W-1:0] prod_sh;
  logic signed [31:0]           prod32;
  logic signed [MSM_ACC_W-1:0]  src_acc;
  logic signed [MSM_ACC_W:0]    diff;
  logic signed [MSM_ACC_W:0]    rnd_val;
  logic                         eff_m40;
  logic                         mac_ovf;
  logic [MSM_ACC_W-1:0]         mac_res;

  assign op_a = opt_uns_t ? {1'b0, mult_temp} : {mult_temp[15], mult_temp};
  assign op_b = opt_uns_x ? {1'b0, xmem_data} : {xmem_data[15], xmem_data};
  assign prod = MSM_PROD_W'(op_a * op_b);
  assign prod_sh = fractional_mode ? (prod <<< 1) : prod;
  assign eff_m40 = wide_40bit_mode | opt_local_m40;

  // Product overflow: with multiply saturation on in fractional mode any product past 32 bits saturates; with signed operands only 8000h x 8000h
  always_comb begin
    prod32 = prod_sh[31:0];
    if (multiply_saturate_mode && fractional_mode &&
        (prod_sh[MSM_PROD_W-1:31] != {(MSM_PROD_W-31){prod_sh[31]}}))
      prod32 = 32'sh7FFFFFFF;
  end

  assign src_acc = dest_is_second ? second_accumulator : first_accumulator;
  assign diff = {src_acc[MSM_ACC_W-1], src_acc}
              - {{(MSM_ACC_W-31){prod32[31]}}, prod32};

  // Round, check overflow at the selected width, then saturate
  always_comb begin
    rnd_val = diff;
    if (opt_round) begin
      rnd_val = diff + 41'sh00000008000;
      if (rounding_mode && rnd_val[15:0] == 16'h0000)
        rnd_val[16] = 1'b0;
      rnd_val[15:0] = 16'h0000;
    end
    if (eff_m40)
      mac_ovf = rnd_val[MSM_ACC_W] != rnd_val[MSM_ACC_W-1];
    else
      mac_ovf = rnd_val[MSM_ACC_W:31] != {(MSM_ACC_W-30){rnd_val[31]}};
    mac_res = rnd_val[MSM_ACC_W-1:0];
    if (mac_ovf && accumulator_saturate_mode) begin
      if (eff_m40)
        mac_res = rnd_val[MSM_ACC_W] ? 40'h8000000000 : 40'h7FFFFFFFFF;
      else
        mac_res = rnd_val[MSM_ACC_W] ? 40'hFF80000000 : 40'h007FFFFFFF;
    end
  end

  // Load path: extend then signed shift left by 16
  logic [MSM_ACC_W-1:0] load_ext;
  logic [MSM_ACC_W-1:0] load_val;
  assign load_ext = sign_extension_mode ? {{24{ymem_data[15]}}, ymem_data}
                                        : {24'h000000, ymem_data};
  assign load_val = eff_m40 ? (load_ext << 16)
                            : {{8{load_ext[15]}}, load_ext[15:0], 16'h0000};

  // Store path: count selection, shift and optional saturation
  logic signed [6:0]           cnt;
  logic signed [6:0]           leg_cnt;
  logic signed [MSM_WORD_W-1:0] cnt16;
  logic signed [MSM_ACC_W+31:0] st_wide;
  logic signed [MSM_ACC_W+31:0] st_shift;
  logic                         st_sat;
  logic                         st_uns;
  logic [MSM_WORD_W-1:0]        st_word;

  always_comb begin
    cnt16 = shift_count_register;
    leg_cnt = {shift_count_register[5], shift_count_register[5:0]};
    if (leg_cnt <= MSM_LEG_LOW && leg_cnt[6])
      leg_cnt = 7'(leg_cnt + MSM_LEG_WRAP);
    if (legacy_compat_mode)
      cnt = leg_cnt;
    else if (cnt16 < MSM_SHIFT_MIN)
      cnt = 7'(MSM_SHIFT_MIN);
    else if (cnt16 > MSM_SHIFT_MAX)
      cnt = 7'(MSM_SHIFT_MAX);
    else
      cnt = cnt16[6:0];
  end

  assign st_sat = legacy_compat_mode & store_saturate_mode;
  assign st_uns = st_sat & ~sign_extension_mode;

  always_comb begin
    st_wide = sign_extension_mode
            ? {{32{first_accumulator[MSM_ACC_W-1]}}, first_accumulator}
            : {32'h00000000, first_accumulator};
    if (cnt[6])
      st_shift = st_wide >>> (-cnt);
    else
      st_shift = st_wide <<< cnt;
    st_word = st_shift[31:16];
    if (st_uns) begin
      if (st_shift[MSM_ACC_W+31:32] != '0)
        st_word = 16'hFFFF;
    end else if (st_sat) begin
      if (st_shift[MSM_ACC_W+31:31] != {(MSM_ACC_W+1){st_shift[31]}})
        st_word = st_shift[MSM_ACC_W+31] ? 16'h8000 : 16'h7FFF;
    end
  end

  // Parallel move and multiply-subtract retire together; repeat just reissues
  logic do_mac;
  logic do_load;
  logic do_store;
  assign do_mac   = issue & (op_kind != MSM_OP_NONE);
  assign do_load  = issue & (op_kind == MSM_OP_LOAD);
  assign do_store = issue & (op_kind == MSM_OP_STORE);

  // AXI write decode signals
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_go;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;

  // Accumulators: datapath writes win over software writes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      first_accumulator  <= '0;
      second_accumulator <= '0;
    end else begin
      if (do_mac && !dest_is_second)
        first_accumulator <= mac_res;
      else if (wr_go && aw_addr == MSM_REG_ACC1_L && w_strb == 4'hF)
        first_accumulator[31:0] <= w_data;
      else if (wr_go && aw_addr == MSM_REG_ACC1_H && w_strb[0])
        first_accumulator[39:32] <= w_data[7:0];
      if (do_mac && dest_is_second)
        second_accumulator <= mac_res;
      else if (do_load)
        second_accumulator <= load_val;
      else if (wr_go && aw_addr == MSM_REG_ACC2_L && w_strb == 4'hF)
        second_accumulator[31:0] <= w_data;
      else if (wr_go && aw_addr == MSM_REG_ACC2_H && w_strb[0])
        second_accumulator[39:32] <= w_data[7:0];
    end
  end

  // Sticky overflow flags, set beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      first_acc_overflow_flag  <= 1'b0;
      second_acc_overflow_flag <= 1'b0;
    end else begin
      if (do_mac && mac_ovf && !dest_is_second)
        first_acc_overflow_flag <= 1'b1;
      else if (wr_go && aw_addr == MSM_REG_STATUS && w_strb[0] && w_data[MSM_B_OV1])
        first_acc_overflow_flag <= 1'b0;
      if (do_mac && mac_ovf && dest_is_second)
        second_acc_overflow_flag <= 1'b1;
      else if (wr_go && aw_addr == MSM_REG_STATUS && w_strb[0] && w_data[MSM_B_OV2])
        second_acc_overflow_flag <= 1'b0;
    end
  end

  // Control, temporaries and pointers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl                     <= MSM_CTRL_RST;
      shift_count_register     <= '0;
      operand_capture_register <= '0;
    end else begin
      if (wr_go && aw_addr == MSM_REG_CTRL && w_strb[0])
        ctrl <= w_data[MSM_CTRL_W-1:0];
      if (do_mac && opt_capture)
        operand_capture_register <= xmem_data;
      else if (wr_go && aw_addr == MSM_REG_TREGS && w_strb[3:2] == 2'h3)
        operand_capture_register <= w_data[31:16];
      if (wr_go && aw_addr == MSM_REG_TREGS && w_strb[1:0] == 2'h3)
        shift_count_register <= w_data[15:0];
    end
  end

  // Paired accesses move both pointers a full long word; plain ones move only the data pointer, by one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      data_pointer        <= '0;
      coefficient_pointer <= '0;
    end else if (issue && op_kind == MSM_OP_DUAL && ptr_post_mod) begin
      data_pointer        <= data_pointer - MSM_PAIR_STEP;
      coefficient_pointer <= coefficient_pointer + MSM_PAIR_STEP;
    end else if (do_mac && ptr_post_mod) begin
      data_pointer        <= data_pointer + MSM_ONE_STEP;
    end else if (wr_go && aw_addr == MSM_REG_PTRS && w_strb == 4'hF) begin
      data_pointer        <= w_data[15:0];
      coefficient_pointer <= w_data[31:16];
    end
  end

  // Store word leaves from a flop one cycle after issue
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ymem_wdata <= '0;
      ymem_we    <= 1'b0;
    end else begin
      ymem_we <= do_store;
      if (do_store)
        ymem_wdata <= st_word;
    end
  end

  // AXI write channel capture, either order
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MSM_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= MSM_REG_PTRS)
                      ? MSM_RESP_OK : MSM_RESP_ERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channel, one outstanding read
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= MSM_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= MSM_RESP_OK;
      case (s_axi_araddr)
        MSM_REG_CTRL:   s_axi_rdata <= {24'h000000, ctrl};
        MSM_REG_STATUS: s_axi_rdata <= {30'h00000000, second_acc_overflow_flag,
                                        first_acc_overflow_flag};
        MSM_REG_ACC1_L: s_axi_rdata <= first_accumulator[31:0];
        MSM_REG_ACC1_H: s_axi_rdata <= {24'h000000, first_accumulator[39:32]};
        MSM_REG_ACC2_L: s_axi_rdata <= second_accumulator[31:0];
        MSM_REG_ACC2_H: s_axi_rdata <= {24'h000000, second_accumulator[39:32]};
        MSM_REG_TREGS:  s_axi_rdata <= {operand_capture_register, shift_count_register};
        MSM_REG_PTRS:   s_axi_rdata <= {coefficient_pointer, data_pointer};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= MSM_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [msm_assertions.sv]
// Port checker for the multiply-subtract block.
// Bound to the block; sees only its top-level ports.
`timescale 1ns/1ps
module msm_checker
  import msm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        issue,
  input wire msm_op_t     op_kind,
  input wire logic        ymem_we,
  input wire logic [15:0] ymem_wdata,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Request steps that the properties start from
  sequence s_store; issue && op_kind == MSM_OP_STORE; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_store_we; s_store |=> ymem_we; endproperty
  property p_no_extra; !(issue && op_kind == MSM_OP_STORE) |=> !ymem_we; endproperty
  property p_word_holds; !(issue && op_kind == MSM_OP_STORE) |=> $stable(ymem_wdata); endproperty
  property p_rd_answer; s_rd |=> s_axi_rvalid; endproperty
  property p_bad_addr;
    s_rd ##0 (s_axi_araddr > MSM_REG_PTRS) |=> s_axi_rresp == MSM_RESP_ERR && s_axi_rdata == 32'h0;
  endproperty
  property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_b_blocks; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_wr_answer; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  a_store_we: assert property (p_store_we) else $error("store word not written");
  a_no_extra: assert property (p_no_extra) else $error("store strobe without store");
  a_word_holds: assert property (p_word_holds) else $error("store word moved");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped read not refused");
  a_ar_blocked: assert property (p_ar_blocked) else $error("read taken while busy");
  a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
  a_b_blocks: assert property (p_b_blocks) else $error("write taken while busy");
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
endmodule

// [msm_dec_model.sv]
// Decoder and memory model: one instruction per call, held operands.
// Assumes the block samples operands on the issue edge.
`timescale 1ns/1ps
module msm_dec_model
  import msm_pkg::*;
(
  input  wire logic   mclk,
  output logic        issue,
  output msm_op_t     op_kind,
  output logic [6:0]  opts,
  output logic [15:0] mult_temp,
  output logic [15:0] xmem_data,
  output logic [15:0] ymem_data
);
  initial begin
    issue = 1'h0;
    op_kind = MSM_OP_NONE;
    opts = 7'h00;
    mult_temp = 16'h0000;
    xmem_data = 16'h0000;
    ymem_data = 16'h0000;
  end
  // Idle cycle: buses scrambled so stale data never looks valid
  task automatic idle();
    @(posedge mclk);
    issue <= 1'h0;
    op_kind <= MSM_OP_NONE;
    xmem_data <= ~xmem_data;
    ymem_data <= ~ymem_data;
  endtask
  // Gap of idle cycles models a slow decoder; zero gives back to back
  task automatic exec(input msm_op_t k, input logic [6:0] o,
                      input logic [15:0] t, x, y, input int gap);
    repeat (gap) idle();
    @(posedge mclk);
    issue <= 1'h1;
    op_kind <= k;
    opts <= o;
    mult_temp <= t;
    xmem_data <= x;
    ymem_data <= y;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the multiply-subtract block.
// Assumes the package, block, decoder model and checker compile first.
`timescale 1ns/1ps
module tb_top;
  import msm_pkg::*;
  logic               mclk = 1'h0;
  logic               rstn = 1'h0;
  logic               issue, ymem_we;
  msm_op_t            op_kind;
  logic [6:0]         opts;
  logic [15:0]        mult_temp, xmem_data, ymem_data, ymem_wdata;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
  logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [33:0]        bus_q[$];
  logic [15:0]        st_q[$];
  int                 n_mismatch = 0;
  int                 compares = 0;
  logic signed [15:0] t, x;
  logic signed [39:0] acc;
  always #50 mclk = ~mclk;
  msm_dec_model u_dec (.mclk, .issue, .op_kind, .opts, .mult_temp, .xmem_data, .ymem_data);
  msm_mac_subtract_move DUT (
    .mclk, .rstn, .issue, .op_kind, .dest_is_second(opts[0]), .opt_round(opts[1]),
    .opt_capture(opts[2]), .opt_uns_x(opts[3]), .opt_uns_t(opts[4]),
    .opt_local_m40(opts[5]), .ptr_post_mod(opts[6]), .mult_temp, .xmem_data,
    .ymem_data, .ymem_wdata, .ymem_we, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_bus(input logic [33:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD bus t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_st(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD store t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Oldest note is the expectation for each answer
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_bus({s_axi_rresp, s_axi_rdata}, bus_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_bus({s_axi_bresp, 32'h0}, bus_q.pop_front());
    if (ymem_we) cmp_st(ymem_wdata, st_q.size() ? st_q.pop_front() : 'x);
  end
  // Address and data offered together; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, b;
    int n;
    bus_q.push_back({(a > MSM_REG_PTRS) ? MSM_RESP_ERR : MSM_RESP_OK, 32'h0});
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    {aw, w, b} = 3'h7;
    n = 0;
    while (b && n < 50) begin
      @(posedge mclk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid) begin
        b = 0;
        s_axi_bready <= 1'h0;
      end
    end
    if (b) n_mismatch++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bit b;
    int n;
    bus_q.push_back({(a > MSM_REG_PTRS) ? MSM_RESP_ERR : MSM_RESP_OK, e});
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    b = 1;
    n = 0;
    while (b && n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        b = 0;
        s_axi_rready <= 1'h0;
      end
    end
    if (b) n_mismatch++;
  endtask
  task automatic set_acc(input bit d, input logic [39:0] v);
    wr(d ? MSM_REG_ACC2_L : MSM_REG_ACC1_L, v[31:0]);
    wr(d ? MSM_REG_ACC2_H : MSM_REG_ACC1_H, {24'h0, v[39:32]});
  endtask
  task automatic chk_acc(input bit d, input logic [39:0] e);
    rd(d ? MSM_REG_ACC2_L : MSM_REG_ACC1_L, e[31:0]);
    rd(d ? MSM_REG_ACC2_H : MSM_REG_ACC1_H, {24'h0, e[39:32]});
  endtask
  // One multiply-subtract from a known accumulator
  task automatic mac(input logic [7:0] c, input logic [6:0] o,
                     input logic [15:0] mt, mx, input logic [39:0] a, e);
    wr(MSM_REG_CTRL, {24'h0, c});
    set_acc(o[0], a);
    u_dec.exec(MSM_OP_DUAL, o, mt, mx, 16'h0, 0);
    u_dec.idle();
    chk_acc(o[0], e);
  endtask
  // Store of the first accumulator; the subtract goes to the second
  task automatic st(input logic [7:0] c, input logic [15:0] n,
                    input logic [39:0] a, input logic [15:0] e);
    wr(MSM_REG_CTRL, {24'h0, c});
    wr(MSM_REG_TREGS, {16'h0, n});
    set_acc(1'h0, a);
    st_q.push_back(e);
    // Local 40-bit mode keeps the second accumulator clear of a 32-bit overflow
    u_dec.exec(MSM_OP_STORE, 7'h21, 16'h0, 16'h0, 16'h0, 0);
    u_dec.idle();
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(65));
    repeat (12) @(posedge mclk);
    rstn <= 1'h1;
    rd(MSM_REG_CTRL, 32'h20);
    rd(MSM_REG_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h1);
    $display("test reset done");
    // Random operands, back to back or with decoder gaps
    wr(MSM_REG_CTRL, 32'h24);
    acc = '0;
    for (int i = 0; i < 8; i++) begin
      t = 16'($urandom);
      x = 16'($urandom);
      acc = acc - 40'(t) * 40'(x);
      u_dec.exec(MSM_OP_DUAL, 7'h00, t, x, 16'h0, $urandom % 2);
    end
    u_dec.idle();
    chk_acc(1'h0, acc);
    mac(8'h25, 7'h00, 16'h0003, 16'h0002, 40'h0, 40'hFFFFFFFFF4);
    mac(8'h24, 7'h08, 16'h0001, 16'hFFFF, 40'h0, 40'hFFFFFF0001);
    mac(8'h27, 7'h00, 16'h8000, 16'h8000, 40'h0, 40'hFF80000001);
    mac(8'h24, 7'h02, 16'h0000, 16'h0000, 40'h29000, 40'h30000);
    mac(8'h24, 7'h00, 16'h0000, 16'h0000, 40'h29000, 40'h29000);
    $display("test multiply done");
    wr(MSM_REG_PTRS, 32'h200010FE);
    u_dec.exec(MSM_OP_DUAL, 7'h40, 16'h0, 16'h0, 16'h0, 0);
    u_dec.idle();
    rd(MSM_REG_PTRS, 32'h200210FC);
    wr(MSM_REG_CTRL, 32'h20);
    u_dec.exec(MSM_OP_LOAD, 7'h04, 16'h0, 16'hBEEF, 16'h8001, 1);
    u_dec.idle();
    chk_acc(1'h1, 40'hFF80010000);
    rd(MSM_REG_TREGS, 32'hBEEF0000);
    wr(MSM_REG_CTRL, 32'h04);
    u_dec.exec(MSM_OP_LOAD, 7'h00, 16'h0, 16'h0, 16'h8001, 0);
    u_dec.idle();
    chk_acc(1'h1, 40'h0080010000);
    $display("test load done");
    st(8'h20, 16'h0004, 40'h0000010001, 16'h0010);
    st(8'h20, 16'h0044, 40'h0000010001, 16'h8000);
    st(8'hA0, 16'h0044, 40'h0000010001, 16'h0010);
    st(8'hA0, 16'h002C, 40'h0012340000, 16'h0123);
    st(8'h20, 16'hFFF0, 40'hFF80000000, 16'hFFFF);
    st(8'h00, 16'hFFF0, 40'hFF80000000, 16'h00FF);
    st(8'hE0, 16'h0000, 40'h0100000000, 16'h7FFF);
    st(8'hC0, 16'h0000, 40'h0100000000, 16'hFFFF);
    $display("test store done");
    rd(MSM_REG_STATUS, 32'h0);
    mac(8'h30, 7'h00, 16'h0001, 16'h0001, 40'hFF80000000, 40'hFF80000000);
    mac(8'h20, 7'h01, 16'h0001, 16'h0001, 40'hFF80000000, 40'hFF7FFFFFFF);
    rd(MSM_REG_STATUS, 32'h3);
    mac(8'h24, 7'h00, 16'h0000, 16'h0000, 40'h29000, 40'h29000);
    rd(MSM_REG_STATUS, 32'h3);
    wr(MSM_REG_STATUS, 32'h3);
    rd(MSM_REG_STATUS, 32'h0);
    $display("test overflow done");
    repeat (4) @(posedge mclk);
    print_verdict();
  end
endmodule
bind msm_mac_subtract_move msm_checker u_chk (
  .mclk, .rstn, .issue, .op_kind, .ymem_we, .ymem_wdata, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
